//--- rtl/ctq_tx_queue_filter.v
// can transmit queue (three buffers, local priority, abort) and identifier acceptance filter
// assumes an ahb-lite master, and a bit engine on the same clock giving start/done/err pulses
//
// Summary of operation
// - three transmit buffers of twelve bytes each: identifier, control and data
// - each transmit buffer has a software-writable eight-bit local priority field
// - successful send sets the empty flag; interrupt while set unless masked
// - among scheduled buffers the smallest local priority value is sent first
// - priorities are chosen afresh at every arbitration, including error retries
// - abort request on idle buffer sets abort ack and empty; active one completes
// - abort ack reads one when aborted, zero when the message was really sent
// - four pattern and four mask bytes; a set mask bit makes that bit don't-care
// - accepted message sets rx full and a two-bit hit; lowest filter wins
// - single mode: one 32-bit filter over full extended or standard identifier
// - dual mode: two 16-bit filters over 14 extended or 11 standard bits
// - quad mode: four 8-bit filters over the first eight identifier bits
// - closed mode: nothing copied to host buffer and rx full never sets
// - second filter byte is compared with de-stuffed identifier bits
// - flags clear by writing one; a hardware set in the same cycle wins over the clear
// - accepted message copied to host buffer only while rx full is clear
`timescale 1ns/1ps
`include "ctq_regs.vh"
module ctq_tx_queue_filter #(
  parameter NBUF = 3
)(
  // clock, reset, enable
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // bit engine: transmit
  input wire tx_arb_start,
  input wire tx_done,
  input wire tx_err,
  output reg tx_req_ff,
  output reg [1:0] tx_sel_ff,
  output reg tx_active_ff,
  // bit engine: receive (de-stuffed identifier word, layout of the pattern registers)
  input wire rx_msg_valid,
  input wire [31:0] rx_id_word,
  input wire rx_ide,
  // interrupt
  output reg irq_ff
);
  // ************************************
  // storage
  // ************************************
  reg [31:0] buf_mem [0:NBUF*4-1]; // three words of payload per buffer
  reg [7:0] local_priority_field_ff [0:NBUF-1];
  reg [NBUF-1:0] txe_ff;
  reg [NBUF-1:0] abt_rq_ff;
  reg [NBUF-1:0] abt_ak_ff;
  reg [NBUF-1:0] txe_mask_ff;
  reg rxf_mask_ff;
  reg [31:0] pat_ff;
  reg [31:0] msk_ff;
  reg [1:0] mode_ff;
  reg [1:0] hit_ff;
  reg rxf_ff;
  reg [31:0] rx_host_ff;
  // address phase capture
  reg wr_pend_ff;
  reg [7:0] addr_ff;
  reg [31:0] nxt_rdata;
  wire aphase = hsel & hready & htrans[1];
  wire wr_now = wr_pend_ff & clk_en;
  integer i;
  integer k; // loop index of the combinational selector only, so i has one driver
  // ************************************
  // priority selection over scheduled buffers
  // ************************************
  reg [1:0] best_idx;
  reg [7:0] best_pri;
  reg best_ok;
  always @*
  begin
    best_idx = 2'h0;
    best_pri = 8'hff;
    best_ok = 1'b0;
    for (k = 0; k < NBUF; k = k + 1)
      if (!txe_ff[k] && !abt_rq_ff[k] && (!best_ok || local_priority_field_ff[k] < best_pri))
      begin
        best_ok = 1'b1;
        best_pri = local_priority_field_ff[k];
        best_idx = k[1:0];
      end
  end
  // ************************************
  // acceptance filter
  // ************************************
  // the identifier word is already de-stuffed by the bit engine, so the second
  // byte never sees the pre-shift value that caused false rejects
  wire [31:0] eq = ~(rx_id_word ^ pat_ff) | msk_ff;
  reg acc;
  reg [1:0] hit;
  always @*
  begin
    acc = 1'b0;
    hit = 2'h0;
    case (mode_ff)
      `CTQ_MODE_SINGLE:
      begin
        // standard frames only compare the first 13 bits (id, rtr, ide)
        acc = rx_ide ? &eq : &eq[31:19];
      end
      `CTQ_MODE_DUAL:
      begin
        // 16 bits per filter: 14 id bits + srr + ide, or 11 id + rtr + ide
        if (rx_ide ? &eq[31:16] : &eq[31:19])
          acc = 1'b1;
        else if (rx_ide ? &{~(rx_id_word[31:16] ^ pat_ff[15:0]) | msk_ff[15:0]}
                 : &{~(rx_id_word[31:19] ^ pat_ff[15:3]) | msk_ff[15:3]})
        begin
          acc = 1'b1;
          hit = 2'h1;
        end
      end
      `CTQ_MODE_QUAD:
      begin
        // each byte of the bank is a filter on the first eight id bits
        if (&(~(rx_id_word[31:24] ^ pat_ff[31:24]) | msk_ff[31:24]))
          acc = 1'b1;
        else if (&(~(rx_id_word[31:24] ^ pat_ff[23:16]) | msk_ff[23:16]))
        begin
          acc = 1'b1;
          hit = 2'h1;
        end
        else if (&(~(rx_id_word[31:24] ^ pat_ff[15:8]) | msk_ff[15:8]))
        begin
          acc = 1'b1;
          hit = 2'h2;
        end
        else if (&(~(rx_id_word[31:24] ^ pat_ff[7:0]) | msk_ff[7:0]))
        begin
          acc = 1'b1;
          hit = 2'h3;
        end
      end
      default:
        acc = 1'b0;
    endcase
  end
  // ************************************
  // read mux
  // ************************************
  always @*
  begin
    nxt_rdata = 32'h0;
    if (haddr < `CTQ_TX_FLAG)
    begin
      if (haddr[3:0] == `CTQ_LOCAL_PRIORITY_FIELD_OFS)
        nxt_rdata = {24'h0, local_priority_field_ff[haddr[5:4]]};
      else
        nxt_rdata = buf_mem[{haddr[5:4], haddr[3:2]}];
    end
    else
      case (haddr)
        `CTQ_TX_FLAG: nxt_rdata = {25'h0, abt_ak_ff, 1'b0, txe_ff};
        `CTQ_TX_CTRL: nxt_rdata = {25'h0, abt_rq_ff, 1'b0, txe_mask_ff};
        `CTQ_IRQ_MASK: nxt_rdata = {28'h0, rxf_mask_ff, txe_mask_ff};
        `CTQ_ACC_PAT: nxt_rdata = pat_ff;
        `CTQ_ACC_MSK: nxt_rdata = msk_ff;
        `CTQ_FILT_CTRL: nxt_rdata = {26'h0, hit_ff, 2'h0, mode_ff};
        `CTQ_RX_FLAG: nxt_rdata = {28'h0, rxf_ff, 3'h0};
        `CTQ_RX_ID: nxt_rdata = rx_host_ff;
        default: nxt_rdata = 32'h0;
      endcase
  end
  // ************************************
  // bus slave: zero wait states, always okay
  // ************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_ff <= aphase & hwrite;
      if (aphase)
        addr_ff <= haddr;
      if (aphase & ~hwrite)
        hrdata <= nxt_rdata;
    end
  end
  // buffer payload words are plain storage
  always @(posedge hclk)
  begin
    if (wr_now && addr_ff < `CTQ_TX_FLAG && addr_ff[3:0] != `CTQ_LOCAL_PRIORITY_FIELD_OFS)
      buf_mem[{addr_ff[5:4], addr_ff[3:2]}] <= hwdata;
  end
  // ************************************
  // control, flags and scheduler
  // ************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < NBUF; i = i + 1)
        local_priority_field_ff[i] <= 8'h0;
      txe_ff <= `CTQ_TXE_RST;
      abt_rq_ff <= {NBUF{1'b0}};
      abt_ak_ff <= {NBUF{1'b0}};
      txe_mask_ff <= {NBUF{1'b0}};
      rxf_mask_ff <= 1'b0;
      pat_ff <= 32'h0;
      msk_ff <= 32'h0;
      mode_ff <= `CTQ_MODE_SINGLE;
      hit_ff <= 2'h0;
      rxf_ff <= 1'b0;
      rx_host_ff <= 32'h0;
      tx_req_ff <= 1'b0;
      tx_sel_ff <= 2'h0;
      tx_active_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      // software writes first; hardware events below take precedence
      if (wr_now)
      begin
        if (addr_ff < `CTQ_TX_FLAG && addr_ff[3:0] == `CTQ_LOCAL_PRIORITY_FIELD_OFS)
          local_priority_field_ff[addr_ff[5:4]] <= hwdata[7:0];
        case (addr_ff)
          `CTQ_TX_FLAG:
            txe_ff <= txe_ff & ~hwdata[NBUF-1:0];
          `CTQ_TX_CTRL:
            abt_rq_ff <= abt_rq_ff | (hwdata[`CTQ_ABT_LSB+NBUF-1:`CTQ_ABT_LSB] & ~txe_ff);
          `CTQ_IRQ_MASK:
          begin
            txe_mask_ff <= hwdata[NBUF-1:0];
            rxf_mask_ff <= hwdata[`CTQ_RXF_BIT];
          end
          `CTQ_ACC_PAT: pat_ff <= hwdata;
          `CTQ_ACC_MSK: msk_ff <= hwdata;
          `CTQ_FILT_CTRL: mode_ff <= hwdata[1:0];
          `CTQ_RX_FLAG:
            if (hwdata[`CTQ_RXF_BIT])
              rxf_ff <= 1'b0;
          default: ;
        endcase
        // a new load clears the old abort ack so it tells the fate of this message
        if (addr_ff == `CTQ_TX_FLAG)
          abt_ak_ff <= abt_ak_ff & ~(hwdata[NBUF-1:0] & txe_ff);
      end
      // arbitration entry (also the retry after an error) picks again
      if (tx_arb_start && !tx_active_ff && best_ok)
      begin
        tx_sel_ff <= best_idx;
        tx_active_ff <= 1'b1;
        tx_req_ff <= 1'b1;
      end
      else if (tx_done)
      begin
        txe_ff[tx_sel_ff] <= 1'b1;
        abt_ak_ff[tx_sel_ff] <= 1'b0;
        abt_rq_ff[tx_sel_ff] <= 1'b0;
        tx_active_ff <= 1'b0;
        tx_req_ff <= 1'b0;
      end
      else if (tx_err)
      begin
        tx_active_ff <= 1'b0;
        tx_req_ff <= 1'b0;
      end
      // aborts on buffers not on the wire are granted at once
      for (i = 0; i < NBUF; i = i + 1)
        if (abt_rq_ff[i] && !(tx_active_ff && tx_sel_ff == i[1:0]))
        begin
          txe_ff[i] <= 1'b1;
          abt_ak_ff[i] <= 1'b1;
          abt_rq_ff[i] <= 1'b0;
        end
      // receive: copy only when accepted and the host buffer is free
      if (rx_msg_valid && acc && !rxf_ff)
      begin
        rxf_ff <= 1'b1;
        hit_ff <= hit;
        rx_host_ff <= rx_id_word;
      end
      irq_ff <= |(txe_ff & ~txe_mask_ff) | (rxf_ff & ~rxf_mask_ff);
    end
  end
endmodule // ctq_tx_queue_filter

//--- rtl/ctq_regs.vh
// register map, field positions and reset values of the tx queue and id filter
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef CTQ_REGS_VH
`define CTQ_REGS_VH
// ************************************
// register offsets (byte addresses)
// ************************************
`define CTQ_TXBUF0 8'h00
`define CTQ_TXBUF_STRIDE 8'h10
`define CTQ_LOCAL_PRIORITY_FIELD_OFS 8'h0c
`define CTQ_TX_FLAG 8'h30
`define CTQ_TX_CTRL 8'h34
`define CTQ_IRQ_MASK 8'h38
`define CTQ_ACC_PAT 8'h3c
`define CTQ_ACC_MSK 8'h40
`define CTQ_FILT_CTRL 8'h44
`define CTQ_RX_FLAG 8'h48
`define CTQ_RX_ID 8'h4c
// ************************************
// field positions and values
// ************************************
`define CTQ_ABT_LSB 4
`define CTQ_RXF_BIT 3
`define CTQ_MODE_SINGLE 2'h0
`define CTQ_MODE_DUAL 2'h1
`define CTQ_MODE_QUAD 2'h2
`define CTQ_MODE_CLOSED 2'h3
`define CTQ_TXE_RST 3'h7
`endif

//--- testbench/ctq_props.sv
// checker on the ports of the tx queue and id filter
// assumes one clock, clk_en held high by the bench
`timescale 1ns/1ps
module ctq_props #(
  parameter NBUF = 3
)(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus answer
  input wire hreadyout,
  input wire hresp,
  // engine side and interrupt
  input wire tx_arb_start,
  input wire tx_done,
  input wire tx_err,
  input wire tx_req_ff,
  input wire [1:0] tx_sel_ff,
  input wire tx_active_ff,
  input wire irq_ff
);
  // ********
  // port relations
  // ********
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_okay_resp: assert property (!hresp) else $error("non-okay response");
  a_zero_wait: assert property (hreadyout) else $error("wait state seen");
  a_sel_range: assert property (tx_req_ff |-> tx_sel_ff < NBUF)
    else $error("selected buffer out of range");
  a_irq_reset: assert property ($rose(hresetn) |-> ##[0:2] irq_ff)
    else $error("empty flags not pending after reset");
  a_active_cause: assert property ($rose(tx_active_ff) |->
    $past(tx_arb_start) || $past(tx_arb_start, 2)) else $error("send without arbitration");
  a_done_ends: assert property (tx_done |-> ##[1:2] !tx_active_ff)
    else $error("active after done");
  a_err_ends: assert property (tx_err |-> ##[1:2] !tx_active_ff)
    else $error("active after error");
  // an abort must never move the buffer that is on the wire
  a_sel_hold: assert property (tx_active_ff && !tx_done && !tx_err && !tx_arb_start
    |=> $stable(tx_sel_ff)) else $error("selection moved while sending");
endmodule // ctq_props

//--- testbench/ctq_bus_model.sv
// model of the bit engine and the other nodes on the can bus
// assumes one clock; every event is a one-cycle pulse launched after a rising edge
`timescale 1ns/1ps
module ctq_bus_model (
  // clock
  input wire hclk,
  // transmit events
  output reg tx_arb_start,
  output reg tx_done,
  output reg tx_err,
  // received frames
  output reg rx_msg_valid,
  output reg [31:0] rx_id_word,
  output reg rx_ide
);
  // idle lines at time zero
  initial
  begin
    {tx_arb_start, tx_done, tx_err, rx_msg_valid, rx_ide} = 5'h00;
    rx_id_word = 32'h0;
  end
  // k: 0 arbitration, 1 frame sent, 2 error; gap gives a slow answer
  task pulse(input [1:0] k, input int gap);
    begin
      repeat (gap) @(posedge hclk);
      tx_arb_start <= k == 2'h0;
      tx_done <= k == 2'h1;
      tx_err <= k == 2'h2;
      @(posedge hclk);
      {tx_arb_start, tx_done, tx_err} <= 3'h0;
    end
  endtask
  // a finished frame; the word is inverted after so no stale id stands
  task rx(input [31:0] id, input ide);
    begin
      @(posedge hclk);
      rx_msg_valid <= 1'b1;
      rx_id_word <= id;
      rx_ide <= ide;
      @(posedge hclk);
      rx_msg_valid <= 1'b0;
      rx_id_word <= ~id;
    end
  endtask
endmodule // ctq_bus_model

//--- testbench/tb_top.sv
// self-checking bench for the can tx queue and id filter
// assumes the rtl block and the bus model; one 50 MHz clock
`timescale 1ns/1ps
module tb_top;
  // ********
  // signals
  // ********
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg rd_dp = 1'b0;
  wire [31:0] hrdata, rx_id_word;
  wire hreadyout, hresp, tx_arb_start, tx_done, tx_err, rx_msg_valid, rx_ide;
  wire tx_req_ff, tx_active_ff, irq_ff;
  wire [1:0] tx_sel_ff;
  reg [31:0] exp_q[$];
  reg [15:0] lfsr = 16'ha156;
  int fail_count = 0;
  int cmp_count = 0;
  int i, j;
  always #10 hclk = ~hclk;
  ctq_tx_queue_filter #(.NBUF(3)) DUT (.hclk, .hresetn, .clk_en(1'b1), .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .tx_arb_start, .tx_done, .tx_err, .tx_req_ff, .tx_sel_ff, .tx_active_ff, .rx_msg_valid,
    .rx_id_word, .rx_ide, .irq_ff);
  ctq_bus_model m (.hclk, .tx_arb_start, .tx_done, .tx_err, .rx_msg_valid, .rx_id_word, .rx_ide);
  // ********
  // tasks
  // ********
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // bounded wait on hreadyout (s=0) or on the buffer going onto the wire (s=1)
  task wt(input s);
    int n;
    begin
      n = 0;
      @(posedge hclk);
      while ((s ? tx_active_ff : hreadyout) !== 1'b1)
      begin
        n = n + 1;
        if (n > 50)
        begin
          fail_count = fail_count + 1;
          $display("FAIL %0t wait timed out", $time);
          print_verdict;
        end
        @(posedge hclk);
      end
    end
  endtask
  // one single ahb transfer; a read notes d as its expected data
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wt(0);
      htrans <= 2'h0;
      hwdata <= d;
      rd_dp <= !w;
      if (!w)
        exp_q.push_back(d);
      wt(0);
      rd_dp <= 1'b0;
    end
  endtask
  task irq(input v);
    begin
      repeat (2) @(posedge hclk);
      #1 chk({31'h0, irq_ff}, {31'h0, v});
    end
  endtask
  task sel(input [1:0] s);
    begin
      m.pulse(0, 1);
      wt(1);
      chk({29'h0, tx_req_ff, tx_sel_ff}, {29'h0, 1'b1, s});
    end
  endtask
  // read data is taken at the edge that ends its data phase
  always @(posedge hclk)
    if (rd_dp === 1'b1 && hreadyout === 1'b1)
      chk(hrdata, exp_q.pop_front());
  initial
  begin
    #2000000;
    fail_count = fail_count + 1;
    $display("FAIL %0t run timed out", $time);
    print_verdict;
  end
  // ********
  // scenarios
  // ********
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 8'h30, 32'h07);
    bus(0, 8'h34, 32'h00);
    irq(1);
    // random payloads; priorities 30, 10, 20 with junk above the field
    for (i = 0; i < 3; i++)
    begin
      for (j = 0; j < 3; j++)
      begin
        lfsr = nxt(lfsr);
        bus(1, 8'(16 * i + 4 * j), {lfsr, ~lfsr});
        bus(0, 8'(16 * i + 4 * j), {lfsr, ~lfsr});
      end
      bus(1, 8'(16 * i + 12), {24'hffffff, 8'(i ? 16 * i : 48)});
      bus(0, 8'(16 * i + 12), {24'h0, 8'(i ? 16 * i : 48)});
    end
    bus(1, 8'h30, 32'h07);
    irq(0);
    sel(1);
    m.pulse(2, 3);
    bus(1, 8'h2c, 32'h05);
    sel(2);
    m.pulse(1, 2);
    sel(1);
    bus(1, 8'h34, 32'h30);
    m.pulse(1, 5);
    bus(0, 8'h30, 32'h17);
    bus(1, 8'h38, 32'h07);
    irq(0);
    // single filter, low byte don't-care, second byte masked 1111 xxx1
    bus(1, 8'h3c, 32'h123c5678);
    bus(1, 8'h40, 32'h00f100ff);
    bus(1, 8'h44, 32'h0);
    lfsr = nxt(lfsr);
    m.rx(32'h123e5600, 1'b1);
    irq(0);
    m.rx({16'h12cd, 8'h56, lfsr[7:0]}, 1'b1);
    irq(1);
    bus(0, 8'h48, 32'h08);
    bus(0, 8'h44, 32'h00);
    bus(1, 8'h48, 32'h08);
    irq(0);
    // quad: filters 1 and 3 both match, the lower is reported
    bus(1, 8'h3c, 32'h11223322);
    bus(1, 8'h40, 32'h0);
    bus(1, 8'h44, 32'h2);
    m.rx({8'h22, lfsr, 8'h00}, 1'b0);
    bus(0, 8'h44, 32'h12);
    bus(1, 8'h48, 32'h08);
    // dual: only the second 16-bit filter matches the top half
    bus(1, 8'h3c, 32'h56781234);
    bus(1, 8'h44, 32'h1);
    m.rx({16'h1234, lfsr}, 1'b1);
    bus(0, 8'h44, 32'h11);
    bus(1, 8'h48, 32'h08);
    bus(1, 8'h44, 32'h3);
    m.rx(32'h22000000, 1'b0);
    bus(0, 8'h48, 32'h00);
    print_verdict;
  end
endmodule // tb_top
bind ctq_tx_queue_filter ctq_props #(.NBUF(NBUF)) u_props (.hclk, .hresetn, .hreadyout,
  .hresp, .tx_arb_start, .tx_done, .tx_err, .tx_req_ff, .tx_sel_ff, .tx_active_ff, .irq_ff);
